// ===== rtl/stfr_pkg.sv
// Shared constants and types for the task file register block.
package stfr_pkg;

   // Register indexes seen by the host adapter (task file address).
   localparam logic [3:0] STFR_IDX_ERR     = 4'h1;
   localparam logic [3:0] STFR_IDX_SCNT    = 4'h2;
   localparam logic [3:0] STFR_IDX_SNUM    = 4'h3;
   localparam logic [3:0] STFR_IDX_MID     = 4'h4;
   localparam logic [3:0] STFR_IDX_HIGH    = 4'h5;
   localparam logic [3:0] STFR_IDX_DEVHEAD = 4'h6;
   localparam logic [3:0] STFR_IDX_CMD     = 4'h7;
   localparam logic [3:0] STFR_IDX_CTRL    = 4'he;

   // Device control field positions.
   localparam int STFR_CTL_HBS  = 7;
   localparam int STFR_CTL_ONE  = 3;
   localparam int STFR_CTL_SRB  = 2;
   localparam int STFR_CTL_NIEN = 1;
   localparam int STFR_CTL_ZERO = 0;
   localparam logic [7:0] STFR_CTL_RESET = 8'h08;

   // Device/head and error field positions.
   localparam int STFR_DH_LBA   = 6;
   localparam int STFR_ERR_ABRT = 2;
   localparam logic [7:0] STFR_DH_RESET = 8'ha0;

   // Command codes handled locally.
   localparam logic [7:0] STFR_CMD_CHKPWR  = 8'he5;
   localparam logic [7:0] STFR_CMD_DLMC    = 8'h92;
   localparam logic [7:0] STFR_CMD_DLMCDMA = 8'h93;

   // Power mode answers in sector count.
   localparam logic [7:0] STFR_PWR_IDLE_STD  = 8'h80;
   localparam logic [7:0] STFR_PWR_IDLE_NEPC = 8'hff;

   // Time limits.
   localparam int          STFR_CLK_HZ          = 20_000_000;
   localparam int          STFR_POR_WIN_MS      = 500;
   localparam int          STFR_POR_WIN_CYC     = STFR_CLK_HZ / 1000 * STFR_POR_WIN_MS;
   localparam logic [15:0] STFR_CTLIM_MIN_MS    = 16'h0032;
   localparam int          STFR_ERC_MIN_MS      = 6500;
   localparam int          STFR_ERC_UNIT_MS     = 100;
   localparam logic [15:0] STFR_ERC_MIN_UNITS   = 16'(STFR_ERC_MIN_MS / STFR_ERC_UNIT_MS);

   // Status supplied by the device core.
   typedef struct packed {
      logic busy;
      logic ready;
      logic seek_done;
      logic data_req;
      logic index_pulse;
      logic error;
   } stfr_core_stat_t;

   // Position reported by the core when a command ends.
   typedef struct packed {
      logic        done;
      logic        lba48;
      logic [47:0] lba;
      logic [15:0] cylinder;
      logic [7:0]  sector_count;
      logic [7:0]  error_bits;
   } stfr_done_t;

   // Host-side register access.
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] idx;
      logic [7:0] wdata;
   } stfr_reg_req_t;

endpackage : stfr_pkg

// ===== rtl/stfr_byte_stack.sv
// Two-deep byte register: most recently written byte and the one before it.
`timescale 1ns/1ps
module stfr_byte_stack
   import stfr_pkg::*;
#(
   parameter int W = 8
)
(
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Host write pushes the current byte down
   input  wire logic         host_wr,
   input  wire logic [W-1:0] host_data,
   // Device load at command end sets both bytes
   input  wire logic         dev_load,
   input  wire logic [W-1:0] dev_cur,
   input  wire logic [W-1:0] dev_prev,
   // Stored bytes
   output logic      [W-1:0] cur_q,
   output logic      [W-1:0] prev_q
);

   logic [W-1:0] cur_r;
   logic [W-1:0] cur_nxt;
   logic [W-1:0] prev_r;
   logic [W-1:0] prev_nxt;

   // A device load wins, since the host must not write while the device is busy.
   always_comb
   begin
      cur_nxt  = cur_r;
      prev_nxt = prev_r;
      if (dev_load)
      begin
         cur_nxt  = dev_cur;
         prev_nxt = dev_prev;
      end
      else if (host_wr)
      begin
         prev_nxt = cur_r;
         cur_nxt  = host_data;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cur_r  <= '0;
         prev_r <= '0;
      end
      else
      begin
         cur_r  <= cur_nxt;
         prev_r <= prev_nxt;
      end
   end

   assign cur_q  = cur_r;
   assign prev_q = prev_r;

endmodule : stfr_byte_stack

// ===== rtl/stfr_task_file.sv
// Device-side task file registers: status, command, address bytes, device control.
// Summary of operation
// - Alternate status mirrors primary status bits
// - Alternate status read never acknowledges interrupt
// - Command write starts execution at once
// - High byte holds cylinder or LBA 16-23
// - 48-bit: high previous byte is LBA 40-47
// - Mid byte holds cylinder or LBA 8-15
// - 48-bit: mid previous byte is LBA 32-39
// - Command-block write clears high byte select
// - Soft reset bit holds device in reset
// - Interrupt only when unmasked and device selected
// - Idle power query without EPC returns FFh
// - COMINIT may wait out 500ms after power-on
// - Microcode downloads aborted while security locked
// - Completion time limit floored at 50ms
// - Standby streaming waits for spin-up completion
// - Recovery limit below 6.5s aborts; waits spin-up
// - Primary status read acknowledges pending interrupt
// - Device/head bit 6 selects CHS or LBA
`timescale 1ns/1ps
module stfr_task_file
   import stfr_pkg::*;
#(
   parameter int POR_WIN_CYC = STFR_POR_WIN_CYC
)
(
   // Clock and reset
   input  wire logic            clk,
   input  wire logic            rst,
   // Register access from the link layer
   input  stfr_reg_req_t        reg_req,
   output logic      [7:0]      reg_rdata,
   output logic                 reg_rvalid,
   // Core status and completion
   input  stfr_core_stat_t      core_stat,
   input  stfr_done_t           core_done,
   input  wire logic            dev_selected,
   // Command issue to the core
   output logic                 cmd_start,
   output logic      [7:0]      cmd_code,
   output logic                 cmd_lba_mode,
   output logic                 cmd_abort,
   // Power and security state
   input  wire logic            security_locked,
   input  wire logic            epc_enabled,
   input  wire logic            drive_idle,
   input  wire logic            drive_standby,
   input  wire logic            spinning_up,
   input  wire logic            cmd_streaming,
   input  wire logic            cmd_has_erc,
   // Time limits requested by the host
   input  wire logic [15:0]     ctlim_req_ms,
   input  wire logic [15:0]     erc_req_units,
   output logic      [15:0]     ctlim_eff_ms,
   output logic                 erc_reject,
   output logic                 complete_hold,
   // Reset and link
   input  wire logic            comreset_req,
   output logic                 cominit_send,
   output logic                 soft_reset_hold,
   // Interrupt to host
   output logic                 host_intrq
);

   localparam int PW = $clog2(POR_WIN_CYC + 1);

   logic [7:0]  ctrl_r,      ctrl_nxt;
   logic [7:0]  devhead_r,   devhead_nxt;
   logic [7:0]  err_r,       err_nxt;
   logic        abort_r,     abort_nxt;
   logic        pend_r,      pend_nxt;
   logic        start_r,     start_nxt;
   logic        cabort_r,    cabort_nxt;
   logic [7:0]  code_r,      code_nxt;
   logic [7:0]  rdata_r,     rdata_nxt;
   logic        rvalid_r,    rvalid_nxt;
   logic        creq_r,      creq_nxt;
   logic        cinit_r,     cinit_nxt;
   logic [PW-1:0] por_cnt_r, por_cnt_nxt;

   logic        cmdblk_wr;
   logic        lba_mode;
   logic        hbs;
   logic        dev_load;
   logic        scnt_load;
   logic [7:0]  status;
   logic        wr_cmd;
   logic        local_pwr;
   logic [7:0]  scnt_dev_cur;
   logic [7:0]  high_cur, high_prev, mid_cur, mid_prev;
   logic [7:0]  scnt_cur, scnt_prev, snum_cur, snum_prev;
   logic [7:0]  hi_dcur, hi_dprev, mid_dcur, mid_dprev;

   assign lba_mode  = devhead_r[STFR_DH_LBA];
   assign hbs       = ctrl_r[STFR_CTL_HBS];
   assign cmdblk_wr = reg_req.wr && (reg_req.idx != STFR_IDX_CTRL);
   assign wr_cmd    = reg_req.wr && (reg_req.idx == STFR_IDX_CMD) && !ctrl_r[STFR_CTL_SRB];
   assign local_pwr = wr_cmd && (reg_req.wdata == STFR_CMD_CHKPWR)
                      && !epc_enabled && drive_idle;

   // Position written back at command end follows the address mode.
   always_comb
   begin
      if (lba_mode)
      begin
         mid_dcur = core_done.lba[15:8];
         hi_dcur  = core_done.lba[23:16];
      end
      else
      begin
         mid_dcur = core_done.cylinder[7:0];
         hi_dcur  = core_done.cylinder[15:8];
      end
      mid_dprev = core_done.lba48 ? core_done.lba[39:32] : mid_cur;
      hi_dprev  = core_done.lba48 ? core_done.lba[47:40] : high_cur;
   end

   assign dev_load     = core_done.done;
   assign scnt_load    = core_done.done || local_pwr;
   assign scnt_dev_cur = local_pwr ? STFR_PWR_IDLE_NEPC : core_done.sector_count;

   stfr_byte_stack #(.W(8)) u_high (
      .clk       (clk),
      .rst       (rst),
      .host_wr   (reg_req.wr && reg_req.idx == STFR_IDX_HIGH),
      .host_data (reg_req.wdata),
      .dev_load  (dev_load),
      .dev_cur   (hi_dcur),
      .dev_prev  (hi_dprev),
      .cur_q     (high_cur),
      .prev_q    (high_prev)
   );

   stfr_byte_stack #(.W(8)) u_mid (
      .clk       (clk),
      .rst       (rst),
      .host_wr   (reg_req.wr && reg_req.idx == STFR_IDX_MID),
      .host_data (reg_req.wdata),
      .dev_load  (dev_load),
      .dev_cur   (mid_dcur),
      .dev_prev  (mid_dprev),
      .cur_q     (mid_cur),
      .prev_q    (mid_prev)
   );

   stfr_byte_stack #(.W(8)) u_scnt (
      .clk       (clk),
      .rst       (rst),
      .host_wr   (reg_req.wr && reg_req.idx == STFR_IDX_SCNT),
      .host_data (reg_req.wdata),
      .dev_load  (scnt_load),
      .dev_cur   (scnt_dev_cur),
      .dev_prev  (scnt_cur),
      .cur_q     (scnt_cur),
      .prev_q    (scnt_prev)
   );

   stfr_byte_stack #(.W(8)) u_snum (
      .clk       (clk),
      .rst       (rst),
      .host_wr   (reg_req.wr && reg_req.idx == STFR_IDX_SNUM),
      .host_data (reg_req.wdata),
      .dev_load  (dev_load),
      .dev_cur   (core_done.lba[7:0]),
      .dev_prev  (core_done.lba48 ? core_done.lba[31:24] : snum_cur),
      .cur_q     (snum_cur),
      .prev_q    (snum_prev)
   );

   // Fault and corrected bits are never reported; service is not supported.
   assign status = {core_stat.busy, core_stat.ready, 1'b0,
                    core_stat.seek_done, core_stat.data_req, 1'b0,
                    core_stat.index_pulse, core_stat.error | abort_r};

   always_comb
   begin
      ctrl_nxt    = ctrl_r;
      devhead_nxt = devhead_r;
      err_nxt     = err_r;
      abort_nxt   = abort_r;
      pend_nxt    = pend_r;
      start_nxt   = 1'b0;
      cabort_nxt  = 1'b0;
      code_nxt    = code_r;
      rdata_nxt   = rdata_r;
      rvalid_nxt  = 1'b0;
      creq_nxt    = creq_r;
      cinit_nxt   = 1'b0;
      por_cnt_nxt = por_cnt_r;

      // Power-on window counts once and then stays expired.
      if (por_cnt_r != PW'(POR_WIN_CYC))
      begin
         por_cnt_nxt = por_cnt_r + PW'(1);
      end

      // Register writes.
      if (reg_req.wr)
      begin
         case (reg_req.idx)
            STFR_IDX_CTRL:
            begin
               ctrl_nxt = {reg_req.wdata[STFR_CTL_HBS], 3'b000, 1'b1,
                           reg_req.wdata[STFR_CTL_SRB],
                           reg_req.wdata[STFR_CTL_NIEN], 1'b0};
            end
            STFR_IDX_DEVHEAD:
            begin
               devhead_nxt = reg_req.wdata;
            end
            STFR_IDX_CMD:
            begin
               if (wr_cmd)
               begin
                  abort_nxt = 1'b0;
                  err_nxt   = '0;
                  code_nxt  = reg_req.wdata;
                  if (security_locked && (reg_req.wdata == STFR_CMD_DLMC ||
                                          reg_req.wdata == STFR_CMD_DLMCDMA))
                  begin
                     cabort_nxt = 1'b1;
                     abort_nxt  = 1'b1;
                     err_nxt[STFR_ERR_ABRT] = 1'b1;
                     pend_nxt   = 1'b1;
                  end
                  else if (local_pwr)
                  begin
                     pend_nxt = 1'b1;
                  end
                  else
                  begin
                     start_nxt = 1'b1;
                  end
               end
            end
            default:
            begin
            end
         endcase
         if (cmdblk_wr)
         begin
            ctrl_nxt[STFR_CTL_HBS] = 1'b0;
         end
      end

      // Register reads; while busy every read returns status.
      if (reg_req.rd)
      begin
         rvalid_nxt = 1'b1;
         if (core_stat.busy)
         begin
            rdata_nxt = status;
         end
         else
         begin
            case (reg_req.idx)
               STFR_IDX_ERR:     rdata_nxt = err_r | core_done.error_bits;
               STFR_IDX_SCNT:    rdata_nxt = hbs ? scnt_prev : scnt_cur;
               STFR_IDX_SNUM:    rdata_nxt = hbs ? snum_prev : snum_cur;
               STFR_IDX_MID:     rdata_nxt = hbs ? mid_prev : mid_cur;
               STFR_IDX_HIGH:    rdata_nxt = hbs ? high_prev : high_cur;
               STFR_IDX_DEVHEAD: rdata_nxt = devhead_r;
               STFR_IDX_CMD:     rdata_nxt = status;
               STFR_IDX_CTRL:    rdata_nxt = status;
               default:          rdata_nxt = 8'h00;
            endcase
         end
         // Only the primary status acknowledges; the alternate copy does not.
         if (reg_req.idx == STFR_IDX_CMD)
         begin
            pend_nxt = 1'b0;
         end
      end

      // Completion sets the pending interrupt; a set wins over a same-cycle read.
      if (core_done.done)
      begin
         pend_nxt = 1'b1;
         err_nxt  = err_r | core_done.error_bits;
      end

      // COMRESET: answer only once the power-on window has expired.
      if (comreset_req)
      begin
         creq_nxt    = 1'b1;
         ctrl_nxt    = STFR_CTL_RESET;
         devhead_nxt = STFR_DH_RESET;
         pend_nxt    = 1'b0;
         abort_nxt   = 1'b0;
      end
      else if (creq_r && por_cnt_r == PW'(POR_WIN_CYC))
      begin
         creq_nxt  = 1'b0;
         cinit_nxt = 1'b1;
      end

      // Soft reset drops any pending interrupt and refuses commands.
      if (ctrl_r[STFR_CTL_SRB])
      begin
         pend_nxt  = 1'b0;
         start_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ctrl_r    <= STFR_CTL_RESET;
         devhead_r <= STFR_DH_RESET;
         err_r     <= '0;
         abort_r   <= 1'b0;
         pend_r    <= 1'b0;
         start_r   <= 1'b0;
         cabort_r  <= 1'b0;
         code_r    <= '0;
         rdata_r   <= '0;
         rvalid_r  <= 1'b0;
         creq_r    <= 1'b0;
         cinit_r   <= 1'b0;
         por_cnt_r <= '0;
      end
      else
      begin
         ctrl_r    <= ctrl_nxt;
         devhead_r <= devhead_nxt;
         err_r     <= err_nxt;
         abort_r   <= abort_nxt;
         pend_r    <= pend_nxt;
         start_r   <= start_nxt;
         cabort_r  <= cabort_nxt;
         code_r    <= code_nxt;
         rdata_r   <= rdata_nxt;
         rvalid_r  <= rvalid_nxt;
         creq_r    <= creq_nxt;
         cinit_r   <= cinit_nxt;
         por_cnt_r <= por_cnt_nxt;
      end
   end

   // Time limit handling is combinational so the core sees it with the request.
   assign ctlim_eff_ms  = (ctlim_req_ms < STFR_CTLIM_MIN_MS) ? STFR_CTLIM_MIN_MS
                                                             : ctlim_req_ms;
   assign erc_reject    = cmd_has_erc && (erc_req_units < STFR_ERC_MIN_UNITS);
   assign complete_hold = drive_standby && spinning_up
                          && (cmd_streaming || cmd_has_erc);

   assign host_intrq      = pend_r && !ctrl_r[STFR_CTL_NIEN] && dev_selected;
   assign soft_reset_hold = ctrl_r[STFR_CTL_SRB];
   assign cmd_start       = start_r;
   assign cmd_code        = code_r;
   assign cmd_lba_mode    = lba_mode;
   assign cmd_abort       = cabort_r;
   assign cominit_send    = cinit_r;
   assign reg_rdata       = rdata_r;
   assign reg_rvalid      = rvalid_r;

endmodule : stfr_task_file

// ===== tb/stfr_task_file_assertions.sv
// Port-level checker for the task file register block.
`timescale 1ns/1ps
module stfr_task_file_assertions
   import stfr_pkg::*;
#(
   parameter int POR_WIN_CYC = 50
)
(
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // Host access and link reset
   input stfr_reg_req_t    reg_req,
   input wire logic        comreset_req,
   input wire logic        cominit_send,
   // Core side
   input stfr_done_t       core_done,
   input wire logic        dev_selected,
   input wire logic        security_locked,
   // Command and interrupt
   input wire logic        cmd_start,
   input wire logic        cmd_abort,
   input wire logic        soft_reset_hold,
   input wire logic        host_intrq,
   // Time limits
   input wire logic [15:0] ctlim_req_ms,
   input wire logic [15:0] ctlim_eff_ms,
   input wire logic        cmd_has_erc,
   input wire logic [15:0] erc_req_units,
   input wire logic        erc_reject
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   logic        cmd_wr;
   logic        dl_cmd;
   int unsigned por_cnt_r;
   int unsigned por_cnt_nxt;

   assign cmd_wr = reg_req.wr && reg_req.idx == STFR_IDX_CMD;
   assign dl_cmd = reg_req.wdata == STFR_CMD_DLMC || reg_req.wdata == STFR_CMD_DLMCDMA;

   // Saturating count from release, so the power-on window needs no long repetition.
   always_comb por_cnt_nxt = rst ? 0 : (por_cnt_r > POR_WIN_CYC + 8) ? por_cnt_r : por_cnt_r + 1;
   always_ff @(posedge clk) por_cnt_r <= por_cnt_nxt;

   cmd_start_a: assert property (
      cmd_wr && reg_req.wdata == 8'hc8 && !soft_reset_hold |=> cmd_start)
      else $error("command write did not start execution");
   soft_reset_bit_block_a: assert property (
      cmd_wr && soft_reset_hold |=> !cmd_start && !cmd_abort)
      else $error("command accepted while held in soft reset");
   dl_abort_a: assert property (
      cmd_wr && dl_cmd && security_locked && !soft_reset_hold |=> cmd_abort && !cmd_start)
      else $error("download not aborted while locked");
   alt_no_ack_a: assert property (
      host_intrq && reg_req.rd && !reg_req.wr && reg_req.idx == STFR_IDX_CTRL
      && !comreset_req && !soft_reset_hold |=> host_intrq || !dev_selected)
      else $error("alternate status read cleared the interrupt");
   status_ack_a: assert property (
      reg_req.rd && !reg_req.wr && reg_req.idx == STFR_IDX_CMD && !core_done.done |=> !host_intrq)
      else $error("status read did not clear the interrupt");
   intr_select_a: assert property (
      host_intrq |-> dev_selected)
      else $error("interrupt raised while not selected");
   ctlim_floor_a: assert property (
      ctlim_eff_ms == ((ctlim_req_ms < STFR_CTLIM_MIN_MS) ? STFR_CTLIM_MIN_MS : ctlim_req_ms))
      else $error("completion limit not floored");
   erc_min_a: assert property (
      erc_reject == (cmd_has_erc && erc_req_units < STFR_ERC_MIN_UNITS))
      else $error("recovery limit reject wrong");
   cominit_a: assert property (
      comreset_req && por_cnt_r > POR_WIN_CYC + 4 |-> ##[1:3] cominit_send)
      else $error("link reset not answered after power-on window");
endmodule : stfr_task_file_assertions

bind stfr_task_file stfr_task_file_assertions #(.POR_WIN_CYC(POR_WIN_CYC)) u_stfr_chk (
   .clk(clk), .rst(rst), .reg_req(reg_req), .comreset_req(comreset_req),
   .cominit_send(cominit_send), .core_done(core_done), .dev_selected(dev_selected),
   .security_locked(security_locked), .cmd_start(cmd_start), .cmd_abort(cmd_abort),
   .soft_reset_hold(soft_reset_hold), .host_intrq(host_intrq), .ctlim_req_ms(ctlim_req_ms),
   .ctlim_eff_ms(ctlim_eff_ms), .cmd_has_erc(cmd_has_erc), .erc_req_units(erc_req_units),
   .erc_reject(erc_reject)
);

// ===== tb/stfr_host_model.sv
// Host adapter model: register accesses, link reset and shadow busy.
`timescale 1ns/1ps
module stfr_host_model
   import stfr_pkg::*;
(
   // Clock
   input wire logic       clk,
   // Access toward the device
   output stfr_reg_req_t  reg_req,
   output logic           comreset_req,
   input wire logic [7:0] reg_rdata,
   input wire logic       reg_rvalid
);
   logic       shadow_busy;
   logic [7:0] shadow_ctrl;

   initial
   begin
      reg_req      = '0;
      comreset_req = 1'h0;
      shadow_busy  = 1'h0;
      shadow_ctrl  = STFR_CTL_RESET;
   end

   task automatic wr(input logic [3:0] idx, input logic [7:0] d);
      @(posedge clk);
      reg_req <= '{wr: 1'h1, rd: 1'h0, idx: idx, wdata: d};
      if (idx == STFR_IDX_CMD || (idx == STFR_IDX_CTRL && d[2] != shadow_ctrl[2]))
         shadow_busy = 1'h1;
      if (idx == STFR_IDX_CTRL)
         shadow_ctrl = d;
      @(posedge clk);
      reg_req <= '0;
   endtask : wr

   // A missing answer reads as unknown so that it can never match.
   task automatic rd(input logic [3:0] idx, output logic [7:0] d);
      @(posedge clk);
      reg_req <= '{wr: 1'h0, rd: 1'h1, idx: idx, wdata: 8'h00};
      @(posedge clk);
      reg_req <= '0;
      #1;
      d = reg_rvalid ? reg_rdata : 8'hxx;
      if (idx == STFR_IDX_CMD && reg_rvalid && !reg_rdata[7])
         shadow_busy = 1'h0;
   endtask : rd

   task automatic comreset();
      @(posedge clk);
      comreset_req <= 1'h1;
      shadow_busy = 1'h1;
      shadow_ctrl = STFR_CTL_RESET;
      @(posedge clk);
      comreset_req <= 1'h0;
   endtask : comreset
endmodule : stfr_host_model

// ===== tb/tb.sv
// Self-checking bench for the task file register block.
`timescale 1ns/1ps
module tb
   import stfr_pkg::*;
;
   logic            clk = 1'h0;
   logic            rst = 1'h1;
   stfr_reg_req_t   reg_req;
   logic [7:0]      reg_rdata, cmd_code, d;
   logic            reg_rvalid, cmd_start, cmd_lba_mode, cmd_abort, seen;
   stfr_core_stat_t core_stat = '0;
   stfr_done_t      core_done = '0;
   logic            dev_selected = 1'h1, security_locked = 1'h0, epc_enabled = 1'h1;
   logic            drive_idle = 1'h0, drive_standby = 1'h0, spinning_up = 1'h0;
   logic            cmd_streaming = 1'h0, cmd_has_erc = 1'h0;
   logic [15:0]     ctlim_req_ms = 16'h0064, erc_req_units = 16'h0064, ctlim_eff_ms;
   logic            erc_reject, complete_hold, comreset_req, cominit_send;
   logic            soft_reset_hold, host_intrq;
   logic [7:0]      dl [2] = '{STFR_CMD_DLMC, STFR_CMD_DLMCDMA};
   logic [15:0]     lim [7] = '{16'h0, 16'h31, 16'h32, 16'h33, 16'h40, 16'h41, 16'h42};
   int              num_errors = 0;
   int              n_tests = 0;

   always #25 clk = ~clk;

   stfr_host_model host (.clk(clk), .reg_req(reg_req), .comreset_req(comreset_req),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

   stfr_task_file #(.POR_WIN_CYC(50)) dut (.clk(clk), .rst(rst), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .core_stat(core_stat),
      .core_done(core_done), .dev_selected(dev_selected), .cmd_start(cmd_start),
      .cmd_code(cmd_code), .cmd_lba_mode(cmd_lba_mode), .cmd_abort(cmd_abort),
      .security_locked(security_locked), .epc_enabled(epc_enabled), .drive_idle(drive_idle),
      .drive_standby(drive_standby), .spinning_up(spinning_up), .cmd_streaming(cmd_streaming),
      .cmd_has_erc(cmd_has_erc), .ctlim_req_ms(ctlim_req_ms), .erc_req_units(erc_req_units),
      .ctlim_eff_ms(ctlim_eff_ms), .erc_reject(erc_reject), .complete_hold(complete_hold),
      .comreset_req(comreset_req), .cominit_send(cominit_send),
      .soft_reset_hold(soft_reset_hold), .host_intrq(host_intrq));

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp)
      begin
         $display("mismatch %s expected %h seen %h", nm, exp, got);
         num_errors++;
      end
   endtask : chk

   task automatic report_and_stop();
      if (num_errors == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : report_and_stop

   task automatic rd_chk(input string nm, input logic [3:0] idx, input logic [7:0] exp);
      host.rd(idx, d);
      chk(nm, {8'h00, exp}, {8'h00, d});
   endtask : rd_chk

   // Write, then let the taking edge land before anything is looked at.
   task automatic w(input logic [3:0] idx, input logic [7:0] data);
      host.wr(idx, data);
      #1;
   endtask : w

   task automatic finish_cmd(input logic l48, input logic [47:0] lba, input logic [15:0] cyl);
      @(posedge clk);
      core_done <= '{done: 1'h1, lba48: l48, lba: lba, cylinder: cyl,
                     sector_count: 8'h00, error_bits: 8'h00};
      @(posedge clk);
      core_done <= '0;
      #1;
   endtask : finish_cmd

   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 1'h0;
      core_stat <= '{busy: 1'h0, ready: 1'h1, seek_done: 1'h1, data_req: 1'h0,
                     index_pulse: 1'h1, error: 1'h0};
      // A link reset inside the power-on window is answered only once the window ends.
      host.comreset();
      seen = 1'h0;
      repeat (30)
      begin
         @(posedge clk);
         #1;
         seen = seen | cominit_send;
      end
      chk("cominit_wait", 16'h0, {15'h0, seen});
      rd_chk("alt_status", STFR_IDX_CTRL, 8'h52);
      w(STFR_IDX_MID, 8'h11);
      w(STFR_IDX_MID, 8'h22);
      w(STFR_IDX_HIGH, 8'h33);
      w(STFR_IDX_HIGH, 8'h44);
      w(STFR_IDX_CTRL, 8'h80);
      rd_chk("high_prev", STFR_IDX_HIGH, 8'h33);
      rd_chk("mid_prev", STFR_IDX_MID, 8'h11);
      w(STFR_IDX_SCNT, 8'h01);
      rd_chk("high_cur", STFR_IDX_HIGH, 8'h44);
      rd_chk("mid_cur", STFR_IDX_MID, 8'h22);
      w(STFR_IDX_DEVHEAD, 8'he0);
      w(STFR_IDX_CMD, 8'hc8);
      chk("shadow_busy", 16'h1, host.shadow_busy);
      chk("cmd_start", 16'h1, cmd_start);
      chk("cmd_code", 16'hc8, cmd_code);
      chk("lba_mode", 16'h1, cmd_lba_mode);
      finish_cmd(1'h1, 48'habcdef123456, 16'h0000);
      chk("intrq_set", 16'h1, host_intrq);
      rd_chk("mid_end", STFR_IDX_MID, 8'h34);
      rd_chk("high_end", STFR_IDX_HIGH, 8'h12);
      w(STFR_IDX_CTRL, 8'h80);
      rd_chk("high_end_prev", STFR_IDX_HIGH, 8'hab);
      rd_chk("mid_end_prev", STFR_IDX_MID, 8'hcd);
      host.rd(STFR_IDX_CTRL, d);
      chk("intrq_kept", 16'h1, host_intrq);
      @(posedge clk);
      dev_selected <= 1'h0;
      #1;
      chk("intrq_unsel", 16'h0, host_intrq);
      @(posedge clk);
      dev_selected <= 1'h1;
      w(STFR_IDX_CTRL, 8'h0a);
      chk("intrq_masked", 16'h0, host_intrq);
      w(STFR_IDX_CTRL, 8'h08);
      chk("intrq_unmask", 16'h1, host_intrq);
      host.rd(STFR_IDX_CMD, d);
      chk("intrq_ack", 16'h0, host_intrq);
      w(STFR_IDX_DEVHEAD, 8'ha0);
      chk("chs_mode", 16'h0, cmd_lba_mode);
      finish_cmd(1'h0, 48'h0, 16'hbeef);
      rd_chk("mid_chs", STFR_IDX_MID, 8'hef);
      rd_chk("high_chs", STFR_IDX_HIGH, 8'hbe);
      host.rd(STFR_IDX_CMD, d);
      w(STFR_IDX_CTRL, 8'h0c);
      chk("soft_reset_bit_hold", 16'h1, soft_reset_hold);
      w(STFR_IDX_CMD, 8'hc8);
      chk("soft_reset_bit_block", 16'h0, cmd_start);
      repeat (100) @(posedge clk);
      w(STFR_IDX_CTRL, 8'h08);
      chk("soft_reset_bit_free", 16'h0, soft_reset_hold);
      w(STFR_IDX_CMD, 8'hc8);
      chk("soft_reset_bit_cmd", 16'h1, cmd_start);
      @(posedge clk);
      epc_enabled <= 1'h0;
      drive_idle <= 1'h1;
      w(STFR_IDX_CMD, STFR_CMD_CHKPWR);
      chk("pwr_start", 16'h0, cmd_start);
      rd_chk("pwr_count", STFR_IDX_SCNT, STFR_PWR_IDLE_NEPC);
      @(posedge clk);
      security_locked <= 1'h1;
      foreach (dl[i])
      begin
         w(STFR_IDX_CMD, dl[i]);
         chk("dl_abort", 16'h1, cmd_abort);
         chk("dl_start", 16'h0, cmd_start);
         host.rd(STFR_IDX_ERR, d);
         chk("dl_err", 16'h1, {15'h0, d[STFR_ERR_ABRT]});
      end
      rd_chk("alt_err", STFR_IDX_CTRL, 8'h53);
      for (int i = 0; i < 7; i++)
      begin
         @(posedge clk);
         ctlim_req_ms <= lim[i];
         erc_req_units <= lim[i];
         cmd_has_erc <= 1'h1;
         #1;
         chk("ctlim_eff", (lim[i] < 16'h0032) ? 16'h0032 : lim[i], ctlim_eff_ms);
         chk("erc_reject", {15'h0, lim[i] < 16'h0041}, {15'h0, erc_reject});
      end
      for (int i = 0; i < 16; i++)
      begin
         @(posedge clk);
         {drive_standby, spinning_up, cmd_streaming, cmd_has_erc} <= 4'(i);
         #1;
         chk("hold", {15'h0, i[3] & i[2] & (i[1] | i[0])}, {15'h0, complete_hold});
      end
      seen = 1'h0;
      host.comreset();
      repeat (4)
      begin
         @(posedge clk);
         #1;
         seen = seen | cominit_send;
      end
      chk("cominit", 16'h1, {15'h0, seen});
      report_and_stop();
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      report_and_stop();
   end
endmodule : tb
